// ### pcrc_align_check.sv
// Alignment checker for bursts into the slave port.
`timescale 1ns/100ps
`default_nettype none
module pcrc_align_check (
  // Burst request from the system master.
  input  wire logic        start,
  input  wire logic [31:0] addr,
  input  wire logic [15:0] len_bytes,
  // Result.
  output logic             bad
);
  // ****************************************
  // Check.
  // ****************************************
  // A multi-beat burst must start on and span whole 16-byte units; a single
  // access of four bytes or less is always allowed.
  always_comb begin
    bad = 1'b0;
    if (start && (len_bytes > 16'h0004)) begin
      bad = ((addr[3:0] & pcrc_pkg::ALIGN_MASK) != 4'h0) ||
            ((len_bytes[3:0] & pcrc_pkg::ALIGN_MASK) != 4'h0);
    end
  end
endmodule // pcrc_align_check
`default_nettype wire

// ### pcrc_completer_model.sv
// Behavioural model of the completer on the far side of the link.
`timescale 1ns/100ps
`default_nettype none
module pcrc_completer_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request from the bench: reject or abort picks the outcome.
  input  wire logic        req,
  input  wire logic        reject,
  input  wire logic        abort,
  input  wire logic [3:0]  lat,
  // Parsed completion towards the block.
  output logic             cpl_valid,
  output logic [31:0]      hdr0,
  output logic [31:0]      hdr1,
  output logic [31:0]      hdr2,
  output logic [31:0]      hdr3
);
  logic [3:0] cnt;   // Cycles left until the completion is returned.
  logic [2:0] cause; // Completion status of the pending request.

  // Idle header lines toggle every cycle so that a stale capture shows up.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt       <= 4'h0;
      cause     <= 3'h0;
      cpl_valid <= 1'b0;
      {hdr0, hdr1, hdr2, hdr3} <= '0;
    end else begin
      cpl_valid <= 1'b0;
      {hdr0, hdr1, hdr2, hdr3} <= ~{hdr0, hdr1, hdr2, hdr3};
      if (req) begin
        cnt   <= lat;
        cause <= reject ? pcrc_pkg::CPL_UR : (abort ? pcrc_pkg::CPL_CA : 3'h0);
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          cpl_valid <= 1'b1;
          hdr0      <= 32'h4a00_0001;
          hdr1      <= {8'h5a, cause, 21'h000010};
          hdr2      <= 32'h0000_0100;
          hdr3      <= 32'h0000_00c3;
        end
      end
    end
  end
endmodule // pcrc_completer_model
`default_nettype wire

// ### pcrc_completion_status.sv
// Completion error status, header log and burst alignment monitor.
//
// Behaviour
// - Unsupported request sets both master-abort bits.
// - Completer abort sets both target-abort bits.
// - Received completion header copied into log.
// - Log word one bits 23:21 hold status.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pcrc_completion_status (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Parsed completion from the link.
  input  wire logic        cpl_valid,
  input  wire logic [31:0] cpl_hdr0,
  input  wire logic [31:0] cpl_hdr1,
  input  wire logic [31:0] cpl_hdr2,
  input  wire logic [31:0] cpl_hdr3,
  // Burst request seen on the slave port.
  input  wire logic        burst_start,
  input  wire logic [31:0] burst_addr,
  input  wire logic [15:0] burst_len,
  // Interrupt.
  output logic             irq
);
  // ****************************************
  // State.
  // ****************************************
  typedef struct packed {
    logic [31:0]               hdr0;       // Captured header word zero.
    logic [31:0]               hdr1;       // Captured header word one.
    logic [31:0]               hdr2;       // Captured header word two.
    logic [31:0]               hdr3;       // Captured header word three.
    logic                      cmd_mst;    // Master abort in status-command.
    logic                      cmd_tgt;    // Target abort in status-command.
    logic                      sec_mst;    // Master abort in secondary status.
    logic                      sec_tgt;    // Target abort in secondary status.
    logic [pcrc_pkg::IRQ_W-1:0] irq_stat;  // Sticky events.
    logic [pcrc_pkg::IRQ_W-1:0] irq_mask;  // Interrupt enables.
    logic [31:0]               bad_addr;   // Last misaligned burst start.
    logic [31:0]               rdata;      // Read data register.
  } pcrc_state_t;

  pcrc_state_t st;        // Registered state.
  pcrc_state_t next_st;   // Next state.
  logic        align_bad; // Misaligned burst this cycle.
  logic        is_ur;     // Completion is unsupported request.
  logic        is_ca;     // Completion is completer abort.

  // ****************************************
  // Alignment monitor.
  // ****************************************
  // The slave port cannot fix a bad burst; it only reports it so software can
  // find the master that breaks the alignment limits.
  pcrc_align_check u_align (
    .start     (burst_start),
    .addr      (burst_addr),
    .len_bytes (burst_len),
    .bad       (align_bad)
  );

  // Decode the completion status field of header word one.
  // Only a valid completion is decoded; idle header lines carry no meaning
  // and must never set an abort bit.
  assign is_ur = cpl_valid &&
    (cpl_hdr1[pcrc_pkg::CPL_STATUS_HI:pcrc_pkg::CPL_STATUS_LO] == pcrc_pkg::CPL_UR);
  assign is_ca = cpl_valid &&
    (cpl_hdr1[pcrc_pkg::CPL_STATUS_HI:pcrc_pkg::CPL_STATUS_LO] == pcrc_pkg::CPL_CA);

  // Build one status word with the two abort bits placed.
  function automatic logic [31:0] abort_word(input logic mst, input logic tgt);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[pcrc_pkg::BIT_MST_ABORT] = mst;
    w[pcrc_pkg::BIT_TGT_ABORT] = tgt;
    return w;
  endfunction

  // ****************************************
  // Next state.
  // ****************************************
  // Hardware sets win over software clears in the same cycle, so no event
  // is lost while a handler is acknowledging an older one.
  always_comb begin
    next_st = st;
    // Write-one-to-clear of the sticky bits; the interrupt mask takes a plain write.
    if (reg_wr) begin
      if (reg_addr == pcrc_pkg::OFS_STATUS_COMMAND) begin
        if (reg_wdata[pcrc_pkg::BIT_MST_ABORT]) next_st.cmd_mst = 1'b0;
        if (reg_wdata[pcrc_pkg::BIT_TGT_ABORT]) next_st.cmd_tgt = 1'b0;
      end else if (reg_addr == pcrc_pkg::OFS_SECONDARY) begin
        if (reg_wdata[pcrc_pkg::BIT_MST_ABORT]) next_st.sec_mst = 1'b0;
        if (reg_wdata[pcrc_pkg::BIT_TGT_ABORT]) next_st.sec_tgt = 1'b0;
      end else if (reg_addr == pcrc_pkg::OFS_IRQ_STATUS) begin
        next_st.irq_stat = st.irq_stat & ~reg_wdata[pcrc_pkg::IRQ_W-1:0];
      end else if (reg_addr == pcrc_pkg::OFS_IRQ_MASK) begin
        next_st.irq_mask = reg_wdata[pcrc_pkg::IRQ_W-1:0];
      end
    end
    // Capture every received completion header.
    // Event bits are set after the clears above, so a set always wins.
    if (cpl_valid) begin
      next_st.hdr0 = cpl_hdr0;
      next_st.hdr1 = cpl_hdr1;
      next_st.hdr2 = cpl_hdr2;
      next_st.hdr3 = cpl_hdr3;
      next_st.irq_stat[pcrc_pkg::IRQ_LOG] = 1'b1;
    end
    if (is_ur) begin
      next_st.cmd_mst = 1'b1;
      next_st.sec_mst = 1'b1;
      next_st.irq_stat[pcrc_pkg::IRQ_MST] = 1'b1;
    end
    if (is_ca) begin
      next_st.cmd_tgt = 1'b1;
      next_st.sec_tgt = 1'b1;
      next_st.irq_stat[pcrc_pkg::IRQ_TGT] = 1'b1;
    end
    if (align_bad) begin
      next_st.bad_addr = burst_addr;
      next_st.irq_stat[pcrc_pkg::IRQ_ALIGN] = 1'b1;
    end
    // Read data; unmapped addresses read as zero.
    // A read strobe with no match still answers, with zero, in the next cycle.
    next_st.rdata = pcrc_pkg::RESET_WORD;
    if (reg_rd) begin
      if (reg_addr == pcrc_pkg::OFS_STATUS_COMMAND) begin
        next_st.rdata = abort_word(st.cmd_mst, st.cmd_tgt);
      end else if (reg_addr == pcrc_pkg::OFS_SECONDARY) begin
        next_st.rdata = abort_word(st.sec_mst, st.sec_tgt);
      end else if (reg_addr == pcrc_pkg::OFS_HDR_LOG0) begin
        next_st.rdata = st.hdr0;
      end else if (reg_addr == pcrc_pkg::OFS_HDR_LOG1) begin
        next_st.rdata = st.hdr1;
      end else if (reg_addr == pcrc_pkg::OFS_HDR_LOG2) begin
        next_st.rdata = st.hdr2;
      end else if (reg_addr == pcrc_pkg::OFS_HDR_LOG3) begin
        next_st.rdata = st.hdr3;
      end else if (reg_addr == pcrc_pkg::OFS_IRQ_STATUS) begin
        next_st.rdata = {28'h000_0000, st.irq_stat};
      end else if (reg_addr == pcrc_pkg::OFS_IRQ_MASK) begin
        next_st.rdata = {28'h000_0000, st.irq_mask};
      end else if (reg_addr == pcrc_pkg::OFS_ALIGN_STATUS) begin
        next_st.rdata = st.bad_addr;
      end
    end
  end

  // ****************************************
  // Registers.
  // ****************************************
  // Synchronous reset clears every word; the interrupt mask starts closed.
  // The mask is named again so a non-zero reset value would still take effect.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st          <= '0;
      st.irq_mask <= pcrc_pkg::RESET_MASK;
    end else begin
      st <= next_st;
    end
  end

  // The interrupt is formed from flopped status and mask, so it never glitches
  // on a combinational path from the register port.
  assign reg_rdata = st.rdata;
  assign irq       = |(st.irq_stat & st.irq_mask);

  // ****************************************
  // Assertions.
  // ****************************************
  // Each check but single_ok_a looks one cycle after the event, when the state has been
  // registered and the read port can show it; single_ok_a checks in the same cycle.
  master_abort_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_ur |=> (st.cmd_mst && st.sec_mst))
    else $error("Master abort bits not set after unsupported request.");
  target_abort_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_ca |=> (st.cmd_tgt && st.sec_tgt))
    else $error("Target abort bits not set after completer abort.");
  header_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    cpl_valid |=> (st.hdr0 == $past(cpl_hdr0) && st.hdr3 == $past(cpl_hdr3)))
    else $error("Completion header not captured.");
  status_field_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == pcrc_pkg::OFS_HDR_LOG1)
      |=> (reg_rdata[pcrc_pkg::CPL_STATUS_HI:pcrc_pkg::CPL_STATUS_LO] ==
           $past(st.hdr1[pcrc_pkg::CPL_STATUS_HI:pcrc_pkg::CPL_STATUS_LO])))
    else $error("Logged completion status read back wrongly.");
  // Outside the answer cycle the read port must rest at zero.
  read_idle_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd |=> (reg_rdata == pcrc_pkg::RESET_WORD))
    else $error("Read data not zero outside the answer cycle.");
  // A target abort stays latched until software writes a one over it.
  target_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st.sec_tgt && !is_ca && !(reg_wr && reg_addr == pcrc_pkg::OFS_SECONDARY))
      |=> st.sec_tgt)
    else $error("Secondary target abort bit lost without a clear.");
  // Every captured header also raises its own event bit.
  log_event_a: assert property (@(posedge clk) disable iff (!rst_n)
    cpl_valid |=> st.irq_stat[pcrc_pkg::IRQ_LOG])
    else $error("Header capture event not raised.");
  abort_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st.cmd_mst && !is_ur && !(reg_wr && reg_addr == pcrc_pkg::OFS_STATUS_COMMAND))
      |=> st.cmd_mst)
    else $error("Master abort bit lost without a clear.");
  abort_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == pcrc_pkg::OFS_SECONDARY && reg_wdata[29] && !is_ur)
      |=> !st.sec_mst)
    else $error("Secondary master abort not cleared by write of one.");
  misalign_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (burst_start && burst_len > 16'h0004 && burst_addr[3:0] != 4'h0)
      |=> (st.irq_stat[3] && st.bad_addr == $past(burst_addr)))
    else $error("Misaligned burst not reported.");
  single_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
    (burst_start && burst_len <= 16'h0004) |-> !align_bad)
    else $error("Single access wrongly flagged as misaligned.");
endmodule // pcrc_completion_status
`default_nettype wire

// ### pcrc_pkg.sv
// Package of constants for the completion error status block.
`default_nettype none
package pcrc_pkg;
  // ****************************************
  // Register offsets (byte addresses).
  // ****************************************
  localparam logic [7:0] OFS_STATUS_COMMAND = 8'h04; // Status and command.
  localparam logic [7:0] OFS_SECONDARY      = 8'h1c; // Secondary status.
  localparam logic [7:0] OFS_HDR_LOG0       = 8'h20; // Captured header word zero.
  localparam logic [7:0] OFS_HDR_LOG1       = 8'h24; // Captured header word one.
  localparam logic [7:0] OFS_HDR_LOG2       = 8'h28; // Captured header word two.
  localparam logic [7:0] OFS_HDR_LOG3       = 8'h2c; // Captured header word three.
  localparam logic [7:0] OFS_IRQ_STATUS     = 8'h30; // Sticky event status.
  localparam logic [7:0] OFS_IRQ_MASK       = 8'h34; // Interrupt mask.
  localparam logic [7:0] OFS_ALIGN_STATUS   = 8'h38; // Last misaligned burst address.
  // ****************************************
  // Field positions.
  // ****************************************
  localparam int BIT_TGT_ABORT   = 28; // Received target abort in status words.
  localparam int BIT_MST_ABORT   = 29; // Received master abort in status words.
  localparam int CPL_STATUS_HI   = 23; // Completion status field, top bit.
  localparam int CPL_STATUS_LO   = 21; // Completion status field, low bit.
  localparam int IRQ_MST         = 0;  // Event: unsupported request seen.
  localparam int IRQ_TGT         = 1;  // Event: completer abort seen.
  localparam int IRQ_LOG         = 2;  // Event: header captured.
  localparam int IRQ_ALIGN       = 3;  // Event: misaligned burst seen.
  localparam int IRQ_W           = 4;  // Number of events.
  // ****************************************
  // Encodings and reset values.
  // ****************************************
  localparam logic [2:0]  CPL_UR      = 3'h1; // Unsupported request.
  localparam logic [2:0]  CPL_CA      = 3'h4; // Completer abort.
  localparam logic [3:0]  ALIGN_MASK  = 4'hf; // 16-byte alignment bits.
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000; // Reset of all words.
  localparam logic [3:0]  RESET_MASK  = 4'h0; // Interrupts masked after reset.
endpackage : pcrc_pkg
`default_nettype wire

// ### test_pcrc_completion_status.sv
// Self-checking testbench for the completion error status block.
`timescale 1ns/100ps
`default_nettype none
module test_pcrc_completion_status;
  logic clk, rst_n, reg_wr, reg_rd, cpl_valid, req, rej, abt, burst_start, irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, hdr0, hdr1, hdr2, hdr3, burst_addr;
  logic [3:0]  lat;
  logic [15:0] burst_len;
  int          err_count;
  int          comparisons;

  pcrc_completion_status u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpl_valid(cpl_valid), .cpl_hdr0(hdr0), .cpl_hdr1(hdr1), .cpl_hdr2(hdr2),
    .cpl_hdr3(hdr3), .burst_start(burst_start), .burst_addr(burst_addr),
    .burst_len(burst_len), .irq(irq));
  pcrc_completer_model u_far (.clk(clk), .rst_n(rst_n), .req(req), .reject(rej),
    .abort(abt), .lat(lat), .cpl_valid(cpl_valid), .hdr0(hdr0), .hdr1(hdr1),
    .hdr2(hdr2), .hdr3(hdr3));

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One-cycle write strobe; the slave never stalls.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  // Ask the far side for a completion and wait, bounded, until cpl_valid shows it, one edge before the block captures it.
  task automatic send(input logic r, input logic a, input logic [3:0] l);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    rej <= r;
    abt <= a;
    lat <= l;
    @(posedge clk);
    req <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (cpl_valid !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      finish_test();
    end
  endtask

  task automatic burst(input logic [31:0] a, input logic [15:0] l);
    @(posedge clk);
    burst_start <= 1'b1;
    burst_addr  <= a;
    burst_len   <= l;
    @(posedge clk);
    burst_start <= 1'b0;
  endtask

  logic [31:0] b_addr [4] = '{32'h10, 32'h2, 32'h8, 32'h100};
  logic [15:0] b_len  [4] = '{16'd32, 16'd4, 16'd32, 16'd20};
  logic [31:0] b_exp  [4] = '{32'h0, 32'h0, 32'h8, 32'h8};

  initial begin
    clk = 0; rst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    req = 0; rej = 0; abt = 0; lat = 4'h1; burst_start = 0; burst_addr = 0; burst_len = 0;
    err_count = 0; comparisons = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Reset state, and an unmapped place that ignores writes.
    wr(8'h3c, 32'hffff_ffff);
    for (int i = 0; i < 14; i++) rchk(8'h04 + 8'(i * 4), 32'h0);
    check({31'h0, irq}, 32'h0);
    rchk(8'h3c, 32'h0);
    // Rejected request: unsupported-request completion.
    send(1'b1, 1'b0, 4'h1);
    rchk(pcrc_pkg::OFS_STATUS_COMMAND, 32'h2000_0000);
    rchk(pcrc_pkg::OFS_SECONDARY, 32'h2000_0000);
    rchk(pcrc_pkg::OFS_HDR_LOG0, 32'h4a00_0001);
    rchk(pcrc_pkg::OFS_HDR_LOG1, {8'h5a, 3'b001, 21'h10});
    rchk(pcrc_pkg::OFS_HDR_LOG2, 32'h0000_0100);
    rchk(pcrc_pkg::OFS_HDR_LOG3, 32'h0000_00c3);
    rchk(pcrc_pkg::OFS_IRQ_STATUS, 32'h5);
    check({31'h0, irq}, 32'h0);
    wr(pcrc_pkg::OFS_IRQ_MASK, 32'h1);
    @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h1);
    rchk(pcrc_pkg::OFS_IRQ_MASK, 32'h1);
    // A good completion later must leave the abort bits set.
    send(1'b0, 1'b0, 4'h4);
    rchk(pcrc_pkg::OFS_STATUS_COMMAND, 32'h2000_0000);
    rchk(pcrc_pkg::OFS_HDR_LOG1, {8'h5a, 3'b000, 21'h10});
    wr(pcrc_pkg::OFS_IRQ_STATUS, 32'h1);
    wr(pcrc_pkg::OFS_STATUS_COMMAND, 32'h2000_0000);
    @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h0);
    rchk(pcrc_pkg::OFS_STATUS_COMMAND, 32'h0);
    rchk(pcrc_pkg::OFS_SECONDARY, 32'h2000_0000);
    wr(pcrc_pkg::OFS_SECONDARY, 32'hffff_ffff);
    // Completer abort.
    send(1'b0, 1'b1, 4'h2);
    rchk(pcrc_pkg::OFS_STATUS_COMMAND, 32'h1000_0000);
    rchk(pcrc_pkg::OFS_SECONDARY, 32'h1000_0000);
    rchk(pcrc_pkg::OFS_HDR_LOG1, {8'h5a, 3'b100, 21'h10});
    rchk(pcrc_pkg::OFS_IRQ_STATUS, 32'h6);
    // Bursts: aligned, single, misaligned start, odd length.
    for (int i = 0; i < 4; i++) begin
      wr(pcrc_pkg::OFS_IRQ_STATUS, 32'hffff_ffff);
      burst(b_addr[i], b_len[i]);
      rchk(pcrc_pkg::OFS_IRQ_STATUS, b_exp[i]);
    end
    rchk(pcrc_pkg::OFS_ALIGN_STATUS, 32'h100);
    // A reset in mid-run must clear the sticky words and close the mask.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(pcrc_pkg::OFS_SECONDARY, 32'h0);
    rchk(pcrc_pkg::OFS_IRQ_MASK, 32'h0);
    rchk(pcrc_pkg::OFS_ALIGN_STATUS, 32'h0);
    finish_test();
  end
endmodule // test_pcrc_completion_status
`default_nettype wire
